// ==== msp_defines.svh ====
// Constants for the multibuffer serial port: field positions, reset values and timing counts.
// Assumes inclusion by bare name from the package and from the design modules.
`ifndef MSP_DEFINES_SVH
`define MSP_DEFINES_SVH

// Global control word
`define MSP_GCR_CTRL_BIT 0

// Word format word
`define MSP_FMT_LEN_HI 4
`define MSP_FMT_LEN_LO 0
`define MSP_FMT_PS_HI 15
`define MSP_FMT_PS_LO 8
`define MSP_FMT_PHASE_BIT 16
`define MSP_FMT_POL_BIT 17

// Chip-select delay word
`define MSP_DLY_C2T_HI 15
`define MSP_DLY_C2T_LO 8
`define MSP_DLY_T2C_HI 7
`define MSP_DLY_T2C_LO 0

// Buffer entry fields, sixteen bits each
`define MSP_FIELD_W 16
`define MSP_FIELD_TX 0
`define MSP_FIELD_RX 1
`define MSP_FIELD_CTL 2
`define MSP_FIELD_STAT 3
`define MSP_CTL_FMTSEL_BIT 0
`define MSP_CTL_HOLD_BIT 1
`define MSP_STAT_DONE 16'h0001
`define MSP_STORE_WE 4'hA
`define MSP_ENTRIES 256

// Word length limits
`define MSP_LEN_MIN 5'h02
`define MSP_LEN_MAX 5'h10

// Serial clock and select timing
`define MSP_PS0_PERIOD 9'h002
`define MSP_LEAD_BASE 10'h002
`define MSP_TRAIL_BASE 10'h001
`define MSP_CLK_PERIOD_NS 5
`define MSP_MIN_SCLK_NS 25
`define MSP_MIN_SCLK_CYC ((`MSP_MIN_SCLK_NS + `MSP_CLK_PERIOD_NS - 1) / `MSP_CLK_PERIOD_NS)

`endif

// ==== msp_pkg.sv ====
// Types shared by the multibuffer serial port modules.
// Assumes msp_defines.svh is on the include path.
`include "msp_defines.svh"
package msp_pkg;
	typedef enum logic [3:0] {
		st_idle,
		st_fetch,
		st_load,
		st_lead,
		st_shift,
		st_trail,
		st_pshift,
		st_store
	} msp_state_type;
endpackage

// ==== msp_buffer_ram.sv ====
// Buffer memory of the serial port: one entry holds four sixteen-bit fields.
// Assumes one clock; port b writes win over port a per field in the same cycle.
`timescale 1ns/10ps
`default_nettype none
`include "msp_defines.svh"
module msp_buffer_ram
	import msp_pkg::*;
	#(
	parameter int ENTRIES = `MSP_ENTRIES,
	parameter int AW = $clog2(ENTRIES)
	) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [AW-1:0] a_addr,
	input wire logic [3:0] a_we,
	input wire logic [4*`MSP_FIELD_W-1:0] a_wdata,
	output logic [4*`MSP_FIELD_W-1:0] a_rdata,
	input wire logic [AW-1:0] b_addr,
	input wire logic [3:0] b_we,
	input wire logic [4*`MSP_FIELD_W-1:0] b_wdata,
	output logic [4*`MSP_FIELD_W-1:0] b_rdata
	);

	// One array per field so each field has a single writer process
	for (genvar f = 0; f < 4; f++) begin : g_field
		logic [`MSP_FIELD_W-1:0] mem [ENTRIES];

		// Field write; engine port takes priority on a collision
		always_ff @(posedge core_clk) begin
			if (b_we[f]) begin
				mem[b_addr] <= b_wdata[f*`MSP_FIELD_W +: `MSP_FIELD_W];
			end else if (a_we[f]) begin
				mem[a_addr] <= a_wdata[f*`MSP_FIELD_W +: `MSP_FIELD_W];
			end
		end

		// Registered read data, one cycle after the address
		always_ff @(posedge core_clk or negedge nrst) begin
			if (!nrst) begin
				a_rdata[f*`MSP_FIELD_W +: `MSP_FIELD_W] <= 16'h0000;
				b_rdata[f*`MSP_FIELD_W +: `MSP_FIELD_W] <= 16'h0000;
			end else begin
				a_rdata[f*`MSP_FIELD_W +: `MSP_FIELD_W] <= mem[a_addr];
				b_rdata[f*`MSP_FIELD_W +: `MSP_FIELD_W] <= mem[b_addr];
			end
		end
	end
endmodule
`default_nettype wire

// ==== msp_serial_port.sv ====
// Multibuffer serial port: controller/peripheral shift engine walking a buffer group.
// Assumes all pin inputs synchronous to core_clk and configuration words held stable during a group.
// Summary of operation
// - Word length programmable from two to sixteen
// - Bit rate from eight-bit prescale divider
// - Controller drives clock; peripheral follows external clock
// - Each word picks its own format
// - Unused port pins serve as plain I/O
// - Buffer memory holds 256 entries
// - Entry: transmit, receive, control, status fields
// - Memory split into groups of entries
// - Clock period prescale+1, or two at zero
// - Mode bit zero; phase format bit sixteen
// - Format bit seventeen sets clock idle level
// - Phase 0: data half period before sampling
// - Select leads first edge count+2, hold +3
// - Select trails last edge half+count+1
// - Lead and trail counts in delay register
`timescale 1ns/10ps
`default_nettype none
`include "msp_defines.svh"
module msp_serial_port
	import msp_pkg::*;
	#(
	parameter int ENTRIES = `MSP_ENTRIES,
	parameter int AW = $clog2(ENTRIES)
	) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [31:0] global_control_reg,
	input wire logic [31:0] word_format_reg0,
	input wire logic [31:0] word_format_reg1,
	input wire logic [31:0] select_delay_reg,
	input wire logic [AW-1:0] group_first,
	input wire logic [AW-1:0] group_last,
	input wire logic group_start,
	output logic group_busy,
	output logic group_done,
	output logic period_too_short,
	input wire logic [AW-1:0] host_addr,
	input wire logic [3:0] host_we,
	input wire logic [4*`MSP_FIELD_W-1:0] host_wdata,
	output logic [4*`MSP_FIELD_W-1:0] host_rdata,
	output logic [`MSP_FIELD_W-1:0] rx_buffer,
	output logic rx_buffer_valid,
	input wire logic [3:0] pin_func_en,
	input wire logic [3:0] gpio_out,
	input wire logic [3:0] gpio_dir,
	output logic [3:0] gpio_in,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	input wire logic ctrl_out_data_pin_in,
	output logic ctrl_out_data_pin_out,
	output logic ctrl_out_data_pin_oe,
	input wire logic ctrl_in_data_pin_in,
	output logic ctrl_in_data_pin_out,
	output logic ctrl_in_data_pin_oe,
	input wire logic select_n_pin_in,
	output logic select_n_pin_out,
	output logic select_n_pin_oe
	);

	msp_state_type state;
	logic [AW-1:0] ptr;
	logic [9:0] timer;
	logic cur_ctrl, cur_phase, cur_pol, cur_hold;
	logic [4:0] cur_len;
	logic [7:0] cur_ps;
	logic sclk, cs_active, sclk_in_q;
	logic [16:0] tx_shift;
	logic [`MSP_FIELD_W-1:0] rx_shift;
	logic [4:0] bit_cnt;
	logic [4*`MSP_FIELD_W-1:0] b_rdata, b_wdata;
	logic [3:0] b_we;
	logic [31:0] sel_fmt;
	logic [4:0] sel_len;
	logic sel_hold, last_entry, sclk_act;
	logic [8:0] period, h_idle, h_active;
	logic [9:0] lead_len, trail_len;
	logic [15:0] tx_aligned;
	logic ctl_lead, ctl_trail, p_lead, p_trail, lead_evt, trail_evt;
	logic sample_evt, shift_evt, ctl_done, p_done, din;
	logic [3:0] func_out, func_oe, pin_in, pin_out, pin_oe;

	// Lengths outside two to sixteen are pinned to the nearest limit
	function automatic logic [4:0] msp_clamp_len(input logic [4:0] v);
		logic [4:0] r;
		r = v;
		if (v < `MSP_LEN_MIN) begin
			r = `MSP_LEN_MIN;
		end else if (v > `MSP_LEN_MAX) begin
			r = `MSP_LEN_MAX;
		end
		return r;
	endfunction

	// Format chosen per entry by its control field
	assign sel_fmt = b_rdata[`MSP_FIELD_CTL*`MSP_FIELD_W + `MSP_CTL_FMTSEL_BIT] ?
		word_format_reg1 : word_format_reg0;
	assign sel_len = msp_clamp_len(sel_fmt[`MSP_FMT_LEN_HI:`MSP_FMT_LEN_LO]);
	assign sel_hold = b_rdata[`MSP_FIELD_CTL*`MSP_FIELD_W + `MSP_CTL_HOLD_BIT];
	assign tx_aligned = b_rdata[`MSP_FIELD_TX*`MSP_FIELD_W +: `MSP_FIELD_W] << (`MSP_LEN_MAX - sel_len);
	assign last_entry = (ptr == group_last);

	// Clock period and its halves; an odd period gives the extra cycle to the active half
	assign period = (cur_ps == 8'h00) ? `MSP_PS0_PERIOD : {1'b0, cur_ps} + 9'h001;
	assign h_idle = {1'b0, period[8:1]};
	assign h_active = period - h_idle;
	assign lead_len = {2'h0, select_delay_reg[`MSP_DLY_C2T_HI:`MSP_DLY_C2T_LO]} + `MSP_LEAD_BASE
		+ {9'h000, sel_hold};
	assign trail_len = {1'b0, h_idle} + {2'h0, select_delay_reg[`MSP_DLY_T2C_HI:`MSP_DLY_T2C_LO]}
		+ `MSP_TRAIL_BASE;

	// Edge events for both roles; phase picks which edge samples and which shifts
	assign sclk_act = (sclk != cur_pol);
	assign ctl_lead = ((state == st_lead) || (state == st_shift && !sclk_act)) && timer == 10'h000;
	assign ctl_trail = (state == st_shift) && sclk_act && timer == 10'h000;
	assign p_lead = (state == st_pshift) && !select_n_pin_in && (serial_clock_pin_in != sclk_in_q)
		&& (serial_clock_pin_in != cur_pol);
	assign p_trail = (state == st_pshift) && !select_n_pin_in && (serial_clock_pin_in != sclk_in_q)
		&& (serial_clock_pin_in == cur_pol);
	assign lead_evt = ctl_lead || p_lead;
	assign trail_evt = ctl_trail || p_trail;
	assign sample_evt = cur_phase ? trail_evt : lead_evt;
	assign shift_evt = cur_phase ? lead_evt : trail_evt;
	assign ctl_done = ctl_trail && ((bit_cnt + {4'h0, cur_phase}) == cur_len);
	assign p_done = p_lead | p_trail ? (sample_evt && (bit_cnt + 5'h01) == cur_len) : 1'b0;
	assign din = cur_ctrl ? ctrl_in_data_pin_in : ctrl_out_data_pin_in;

	// Sequencer over the group's entries
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= st_idle;
			ptr <= '0;
			timer <= 10'h000;
		end else begin
			case (state)
				st_idle: begin
					if (group_start) begin
						ptr <= group_first;
						state <= st_fetch;
					end
				end
				st_fetch: begin
					state <= st_load;
				end
				st_load: begin
					timer <= lead_len - 10'h001;
					state <= cur_ctrl ? st_lead : st_pshift;
				end
				st_lead: begin
					if (timer == 10'h000) begin
						timer <= {1'b0, h_active} - 10'h001;
						state <= st_shift;
					end else begin
						timer <= timer - 10'h001;
					end
				end
				st_shift: begin
					if (ctl_done) begin
						timer <= trail_len - 10'h001;
						state <= st_trail;
					end else if (ctl_trail) begin
						timer <= {1'b0, h_idle} - 10'h001;
					end else if (ctl_lead) begin
						timer <= {1'b0, h_active} - 10'h001;
					end else begin
						timer <= timer - 10'h001;
					end
				end
				st_trail: begin
					if (timer == 10'h000) begin
						state <= st_store;
					end else begin
						timer <= timer - 10'h001;
					end
				end
				st_pshift: begin
					if (p_done) begin
						state <= st_store;
					end
				end
				st_store: begin
					if (last_entry) begin
						state <= st_idle;
					end else begin
						ptr <= ptr + 1'b1;
						state <= st_fetch;
					end
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end

	// Per-word format latch; mode is caught once per group
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cur_ctrl <= 1'b0;
			cur_phase <= 1'b0;
			cur_pol <= 1'b0;
			cur_hold <= 1'b0;
			cur_len <= `MSP_LEN_MAX;
			cur_ps <= 8'h00;
		end else if (state == st_idle) begin
			cur_ctrl <= global_control_reg[`MSP_GCR_CTRL_BIT];
			cur_pol <= word_format_reg0[`MSP_FMT_POL_BIT];
			cur_ps <= word_format_reg0[`MSP_FMT_PS_HI:`MSP_FMT_PS_LO];
		end else if (state == st_load) begin
			cur_phase <= sel_fmt[`MSP_FMT_PHASE_BIT];
			cur_pol <= sel_fmt[`MSP_FMT_POL_BIT];
			cur_ps <= sel_fmt[`MSP_FMT_PS_HI:`MSP_FMT_PS_LO];
			cur_len <= sel_len;
			cur_hold <= sel_hold;
		end
	end

	// Serial clock; rests at the polarity level outside a word
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sclk <= 1'b0;
		end else if (state == st_idle) begin
			sclk <= word_format_reg0[`MSP_FMT_POL_BIT];
		end else if (state == st_load) begin
			sclk <= sel_fmt[`MSP_FMT_POL_BIT];
		end else if (ctl_lead) begin
			sclk <= ~cur_pol;
		end else if (ctl_trail) begin
			sclk <= cur_pol;
		end
	end

	// Chip select; kept active across entries that ask for hold
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cs_active <= 1'b0;
		end else if (state == st_load && cur_ctrl) begin
			cs_active <= 1'b1;
		end else if (state == st_trail && timer == 10'h000 && (!cur_hold || last_entry)) begin
			cs_active <= 1'b0;
		end
	end

	// Shift registers; tx has a spare top bit so phase 1 shows the first bit on the first edge
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_shift <= 17'h00000;
			rx_shift <= 16'h0000;
			bit_cnt <= 5'h00;
		end else if (state == st_load) begin
			tx_shift <= sel_fmt[`MSP_FMT_PHASE_BIT] ? {1'b0, tx_aligned} : {tx_aligned, 1'b0};
			rx_shift <= 16'h0000;
			bit_cnt <= 5'h00;
		end else begin
			if (shift_evt) begin
				tx_shift <= {tx_shift[15:0], 1'b0};
			end
			if (sample_evt) begin
				rx_shift <= {rx_shift[14:0], din};
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	// Previous external clock level for edge detection
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_in_q <= 1'b0;
		end else begin
			sclk_in_q <= serial_clock_pin_in;
		end
	end

	// Receive register and status outputs
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rx_buffer <= 16'h0000;
			rx_buffer_valid <= 1'b0;
			group_done <= 1'b0;
			period_too_short <= 1'b0;
		end else begin
			rx_buffer_valid <= (state == st_store);
			group_done <= (state == st_store) && last_entry;
			period_too_short <= period < 9'(`MSP_MIN_SCLK_CYC);
			if (state == st_store) begin
				rx_buffer <= rx_shift;
			end
		end
	end

	assign group_busy = (state != st_idle);

	// Write back receive and status fields of the finished entry
	assign b_we = (state == st_store) ? `MSP_STORE_WE : 4'h0;
	assign b_wdata = {`MSP_STAT_DONE, 16'h0000, rx_shift, 16'h0000};

	msp_buffer_ram #(
		.ENTRIES(ENTRIES),
		.AW(AW)
	) u_ram (
		.core_clk(core_clk),
		.nrst(nrst),
		.a_addr(host_addr),
		.a_we(host_we),
		.a_wdata(host_wdata),
		.a_rdata(host_rdata),
		.b_addr(ptr),
		.b_we(b_we),
		.b_wdata(b_wdata),
		.b_rdata(b_rdata)
	);

	// Functional pin drive; index 0 clock, 1 ctrl-out data, 2 ctrl-in data, 3 select
	assign func_out = {~cs_active, tx_shift[16], tx_shift[16], sclk};
	assign func_oe = {global_control_reg[0], ~global_control_reg[0] & ~select_n_pin_in,
		global_control_reg[0], global_control_reg[0]};
	assign pin_in = {select_n_pin_in, ctrl_in_data_pin_in, ctrl_out_data_pin_in, serial_clock_pin_in};

	// Pins not claimed by the port fall back to plain I/O
	for (genvar i = 0; i < 4; i++) begin : g_pin
		assign pin_out[i] = pin_func_en[i] ? func_out[i] : gpio_out[i];
		assign pin_oe[i] = pin_func_en[i] ? func_oe[i] : gpio_dir[i];
	end

	assign gpio_in = pin_in;
	assign serial_clock_pin_out = pin_out[0];
	assign serial_clock_pin_oe = pin_oe[0];
	assign ctrl_out_data_pin_out = pin_out[1];
	assign ctrl_out_data_pin_oe = pin_oe[1];
	assign ctrl_in_data_pin_out = pin_out[2];
	assign ctrl_in_data_pin_oe = pin_oe[2];
	assign select_n_pin_out = pin_out[3];
	assign select_n_pin_oe = pin_oe[3];

	// Helper counters: cycles since the clock last moved, and since select went active
	logic sclk_q;
	logic [9:0] since_edge, cs_age;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_q <= 1'b0;
			since_edge <= 10'h000;
			cs_age <= 10'h000;
		end else begin
			sclk_q <= sclk;
			since_edge <= (sclk != sclk_q) ? 10'h001 : since_edge + 10'h001;
			cs_age <= cs_active ? cs_age + 10'h001 : 10'h000;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence seq_load;
		state == st_load;
	endsequence
	sequence seq_first_edge;
		sclk != sclk_q && $past(state) == st_lead;
	endsequence

	word_len_range_a: assert property (state == st_shift |-> cur_len >= 5'h02 && cur_len <= 5'h10)
		else $error("word length out of range");
	half_period_a: assert property (sclk != sclk_q && state == st_shift && $past(state) == st_shift
		|-> since_edge == {1'b0, (sclk_q != cur_pol) ? h_active : h_idle})
		else $error("serial clock half period wrong");
	idle_level_a: assert property (state == st_store |-> sclk == cur_pol)
		else $error("serial clock not at idle level");
	format_pick_a: assert property (seq_load |=> cur_len == $past(sel_len)
		&& cur_pol == $past(sel_fmt[17]))
		else $error("entry format not taken");
	lead_count_a: assert property (seq_first_edge and cs_age <= lead_len + 10'h001
		|-> cs_age == lead_len)
		else $error("select lead count wrong");
	trail_count_a: assert property ($fell(cs_active) |-> since_edge == trail_len)
		else $error("select trail count wrong");
	data_setup_a: assert property (cur_ctrl && !cur_phase && state == st_shift
		&& $changed(tx_shift[16]) |-> $past(ctl_trail))
		else $error("data moved off the shift edge");
	rx_store_a: assert property (state == st_store |=> rx_buffer_valid && rx_buffer == $past(rx_shift))
		else $error("received word not stored");
	ram_write_a: assert property (state == st_store |-> b_we == 4'hA ##1 state != st_store)
		else $error("entry write back wrong");
	pin_gpio_a: assert property (!pin_func_en[0] |-> serial_clock_pin_out == gpio_out[0]
		&& serial_clock_pin_oe == gpio_dir[0])
		else $error("plain pin not passed through");
	mode_drive_a: assert property (pin_func_en[0] |-> serial_clock_pin_oe == global_control_reg[0])
		else $error("clock pin drive wrong for mode");
endmodule
`default_nettype wire

// ==== msp_peer_model.sv ====
// Peripheral stand-in on the far side of the serial pins.
// Assumes phase 0; pins change only at core_clk edges.
`timescale 1ns/10ps
`default_nettype none
module msp_peer_model (
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic pol,
	input wire logic din,
	input wire logic [15:0] reply,
	output logic dout,
	output logic [15:0] cap,
	output logic [4:0] bits
	);
	logic [15:0] sh;
	initial begin
		dout = 1'b0;
		cap = '0;
		bits = '0;
		sh = '0;
	end
	// Released line flips so a stale bit is never read as valid
	always @(sel_n) begin
		if (sel_n === 1'b0) begin
			sh = reply;
			cap = '0;
			bits = '0;
			dout = reply[15];
		end else begin
			dout = ~dout;
		end
	end
	// Sample on leading edge, shift on trailing edge
	always @(sclk) begin
		if (sel_n === 1'b0 && sclk !== pol) begin
			cap = {cap[14:0], din};
			bits = bits + 5'h01;
		end else if (sel_n === 1'b0) begin
			sh = {sh[14:0], 1'b0};
			dout = sh[15];
		end
	end
endmodule
`default_nettype wire

// ==== multibuffer_serial_port_tb.sv ====
// Self-checking bench: controller transfers, one peripheral word, pin modes, gpio.
// Assumes the peer model answers as a phase 0 peripheral.
`timescale 1ns/10ps
`default_nettype none
module multibuffer_serial_port_tb;
	logic core_clk, nrst, group_start, group_busy, group_done, period_too_short, rx_buffer_valid;
	logic [31:0] global_control_reg, word_format_reg0, word_format_reg1, select_delay_reg;
	logic [2:0] group_first, group_last, host_addr;
	logic [3:0] host_we, pin_func_en, gpio_out, gpio_dir, gpio_in, ext;
	logic [63:0] host_wdata, host_rdata;
	logic [15:0] rx_buffer, reply, cap;
	logic [4:0] bits;
	logic serial_clock_pin_in, serial_clock_pin_out, serial_clock_pin_oe, pc, pn, peer_out;
	logic ctrl_out_data_pin_in, ctrl_out_data_pin_out, ctrl_out_data_pin_oe;
	logic ctrl_in_data_pin_in, ctrl_in_data_pin_out, ctrl_in_data_pin_oe;
	logic select_n_pin_in, select_n_pin_out, select_n_pin_oe;
	int miscompares, check_count, t_edge, t_lead, nlead, exp_l, exp_p, exp_t, seed;
	logic [15:0] rq[$], exp_rx[$];
	logic [20:0] txq[$];
	int tq[$];
	logic [15:0] ram_rx [0:7];
	// Wire levels: a driven pin shows its driver, else the outside
	assign serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out : ext[0];
	assign ctrl_out_data_pin_in = ctrl_out_data_pin_oe ? ctrl_out_data_pin_out : ext[1];
	assign ctrl_in_data_pin_in = ctrl_in_data_pin_oe ? ctrl_in_data_pin_out : (pin_func_en[2] ? peer_out : ext[2]);
	assign select_n_pin_in = select_n_pin_oe ? select_n_pin_out : ext[3];
	msp_serial_port #(.ENTRIES(8)) dut (.core_clk, .nrst, .global_control_reg, .word_format_reg0,
		.word_format_reg1, .select_delay_reg, .group_first, .group_last, .group_start, .group_busy,
		.group_done, .period_too_short, .host_addr, .host_we, .host_wdata, .host_rdata, .rx_buffer,
		.rx_buffer_valid, .pin_func_en, .gpio_out, .gpio_dir, .gpio_in, .serial_clock_pin_in,
		.serial_clock_pin_out, .serial_clock_pin_oe, .ctrl_out_data_pin_in, .ctrl_out_data_pin_out,
		.ctrl_out_data_pin_oe, .ctrl_in_data_pin_in, .ctrl_in_data_pin_out, .ctrl_in_data_pin_oe,
		.select_n_pin_in, .select_n_pin_out, .select_n_pin_oe);
	msp_peer_model peer (.sclk(serial_clock_pin_out), .sel_n(select_n_pin_out), .pol(word_format_reg0[17]),
		.din(ctrl_out_data_pin_out), .reply(reply), .dout(peer_out), .cap(cap), .bits(bits));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	task automatic check(input string what, input logic [63:0] exp, got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Load one entry and note what the wire and buffer must show
	task automatic put(input int i, input logic fs, hold);
		logic [31:0] f;
		logic [15:0] tx, r;
		int len, p;
		f = fs ? word_format_reg1 : word_format_reg0;
		len = (f[4:0] < 2) ? 2 : (f[4:0] > 16) ? 16 : f[4:0];
		p = (f[15:8] == 0) ? 2 : f[15:8] + 1;
		tx = 16'($urandom);
		r = 16'($urandom);
		@(posedge core_clk);
		host_addr <= 3'(i);
		host_we <= 4'hF;
		host_wdata <= {16'h0000, 14'h0000, hold, fs, 16'h0000, tx}; // Control field holds hold and format pick
		rq.push_back(r);
		ram_rx[i] = r >> (16 - len);
		exp_rx.push_back(ram_rx[i]);
		txq.push_back({5'(len), tx & 16'((32'h1 << len) - 1)});
		tq.push_back(select_delay_reg[15:8] + 2 + hold);
		tq.push_back(p);
		tq.push_back(p / 2 + select_delay_reg[7:0] + 1);
		@(posedge core_clk);
		host_we <= 4'h0;
	endtask
	task automatic run(input logic [2:0] a, b);
		int n;
		@(posedge core_clk);
		group_first <= a;
		group_last <= b;
		group_start <= 1'b1;
		@(posedge core_clk);
		group_start <= 1'b0;
		n = 0;
		while (group_done !== 1'b1 && n < 30000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= 30000) begin
			miscompares++;
			print_verdict();
		end
	endtask
	task automatic rd(input int i);
		@(posedge core_clk);
		host_addr <= 3'(i);
		@(posedge core_clk);
		#1;
		check("rx field", ram_rx[i], host_rdata[31:16]);
		check("status field", 16'h0001, host_rdata[63:48]);
	endtask
	// Pin event timer; sees the values of the cycle just ended
	always @(posedge core_clk) begin
		reply <= (rq.size() > 0) ? rq[0] : 16'h0000;
		t_edge++;
		t_lead++;
		if (nrst && global_control_reg[0] && pin_func_en == 4'hF) begin
			if (pn === 1'b1 && select_n_pin_out === 1'b0) begin
				exp_l = tq.pop_front();
				exp_p = tq.pop_front();
				exp_t = tq.pop_front();
				nlead = 0;
				t_edge = 0;
			end
			if (pc !== serial_clock_pin_out && serial_clock_pin_out !== word_format_reg0[17]) begin
				if (nlead == 0)
					check("lead", exp_l, t_edge);
				else
					check("period", exp_p, t_lead);
				nlead++;
				t_lead = 0;
			end
			if (pc !== serial_clock_pin_out)
				t_edge = 0;
			if (pn === 1'b0 && select_n_pin_out === 1'b1) begin
				check("trail", exp_t, t_edge);
				check("sent word", txq.pop_front(), {bits, cap});
				void'(rq.pop_front());
			end
		end
		pc = serial_clock_pin_out;
		pn = select_n_pin_out;
	end
	// Each stored word is compared with the oldest note
	always @(posedge core_clk) begin
		#1;
		if (rx_buffer_valid === 1'b1)
			check("rx_buffer", exp_rx.pop_front(), rx_buffer);
	end
	initial begin
		{nrst, group_start, host_we, gpio_out, gpio_dir, ext} = '0;
		{group_first, group_last, host_addr, host_wdata} = '0;
		global_control_reg = 32'h0000_0001;
		word_format_reg0 = 32'h0000_0410;
		word_format_reg1 = 32'h0000_0902;
		select_delay_reg = 32'h0000_0302;
		pin_func_en = 4'hF;
		seed = $urandom(32'h1138);
		repeat (4) @(posedge core_clk);
		#1;
		check("busy in reset", 1'b0, group_busy);
		check("select in reset", 1'b1, select_n_pin_out);
		check("clock in reset", 1'b0, serial_clock_pin_out);
		nrst <= 1'b1;
		$display("test reset done");
		// Mixed formats, hold on the last entry only
		put(0, 1'b0, 1'b0);
		put(1, 1'b1, 1'b0);
		put(2, 1'b0, 1'b0);
		put(3, 1'b1, 1'b1);
		run(3'h0, 3'h3);
		for (int i = 0; i < 4; i++)
			rd(i);
		$display("test mixed group done");
		// Idle-high clock, clamped lengths, extreme prescales
		word_format_reg0 <= 32'h0002_0001;
		word_format_reg1 <= 32'h0002_FF1F;
		select_delay_reg <= 32'h0000_0000;
		repeat (3) @(posedge core_clk);
		#1;
		check("clock idle high", 1'b1, serial_clock_pin_out);
		put(5, 1'b0, 1'b0);
		put(6, 1'b1, 1'b1);
		run(3'h5, 3'h6);
		rd(5);
		rd(6);
		check("notes left", 0, exp_rx.size());
		$display("test polarity group done");
		for (int i = 0; i < 3; i++) begin
			word_format_reg0 <= {16'h0000, 8'(i + 3), 8'h10};
			word_format_reg1 <= {16'h0000, 8'(i + 3), 8'h10};
			repeat (3) @(posedge core_clk);
			#1;
			check("period too short", i == 0, period_too_short);
		end
		$display("test short period done");
		// Peripheral mode: the outside owns clock and select
		global_control_reg <= 32'h0000_0000;
		word_format_reg0 <= 32'h0000_0008;
		repeat (2) @(posedge core_clk);
		#1;
		check("peripheral enables", 4'h4, {select_n_pin_oe, ctrl_in_data_pin_oe, ctrl_out_data_pin_oe,
			serial_clock_pin_oe});
		// One word clocked in from outside; select is already low
		put(7, 1'b0, 1'b0);
		fork
			run(3'h7, 3'h7);
			begin
				repeat (6) @(posedge core_clk);
				for (int b = 7; b >= 0; b--) begin
					ext <= {2'b00, rq[0][b + 8], 1'b0}; // Data moves with the trailing edge
					repeat (2) @(posedge core_clk);
					check("peripheral out", txq[0][b], ctrl_in_data_pin_out);
					ext[0] <= 1'b1;
					repeat (2) @(posedge core_clk);
				end
				ext <= 4'h8;
			end
		join
		rd(7);
		void'(rq.pop_front());
		void'(txq.pop_front());
		tq.delete();
		pin_func_en <= 4'h0;
		gpio_dir <= 4'hF;
		gpio_out <= 4'($urandom);
		repeat (2) @(posedge core_clk);
		#1;
		check("gpio drive", {4'hF, gpio_out}, {select_n_pin_oe, ctrl_in_data_pin_oe, ctrl_out_data_pin_oe,
			serial_clock_pin_oe, select_n_pin_out, ctrl_in_data_pin_out, ctrl_out_data_pin_out,
			serial_clock_pin_out});
		gpio_dir <= 4'h0;
		ext <= 4'($urandom);
		repeat (2) @(posedge core_clk);
		#1;
		check("gpio read", ext, gpio_in);
		$display("test pins done");
		print_verdict();
	end
endmodule
`default_nettype wire
